/* File: rtl/cal_device.sv */
// Transceiver control logic: configuration registers, VCO/PLL
// self-calibration sequencer, bank storage, override, power-down and bias.
// Assumes the link is driven on pclk by the controller end.
`timescale 1ns/1ps
`default_nettype none
`include "cal_regs.svh"

// Contract
// - Calibration starts when trigger bit is set
// - Calibration result kept while powered
// - Host polls done flag or waits 34 ms
// - Duration scales inversely with reference frequency
// - Lock pin shows done flag when selected
// - Host clears trigger after calibration
// - Separate calibration values per bank A/B
// - Shared select: one calibration or per bank
// - Readback registers show selected bank values
// - Override values used only when both bits set
// - Independent power-down bits for four sections
// - Host zeroes output power before power-down
// - Host releases strobe high during power-down
// - Programmable oscillator, buffer and amplifier bias fields
module cal_device #(
  parameter int unsigned CAL_REF_CYCLES = `CAL_REF_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  cal_link_if.dev link,
  input wire logic [5:0] tune_found,
  input wire logic [3:0] pump_found,
  output logic [5:0] tune_word,
  output logic [3:0] pump_word,
  output logic rx_pd,
  output logic tx_pd,
  output logic synth_pd,
  output logic xosc_pd,
  output logic [3:0] oscillator_bias_setting,
  output logic [1:0] local_osc_buffer_drive,
  output logic [1:0] amplifier_buffer_drive,
  output logic buf_current,
  output logic [1:0] low_noise_amp_bias,
  output logic [7:0] output_power_setting
);

  localparam logic [15:0] PHASE_LAST = 16'(CAL_REF_CYCLES / 2 - 1);

  // ==========================================================
  // Registers
  logic [4:0] main_q;
  logic cal_start_q;
  logic cal_shared_q;
  logic cal_wait_q;
  logic cal_done_q;
  logic [3:0] lock_sel_q;
  logic [7:0] current_q;
  logic [2:0] front_q;
  logic [7:0] output_power_setting_q;
  logic [7:0] ovr_vco_q;
  logic [7:0] ovr_pump_q;
  logic [7:0] ref_div_q;
  logic [7:0] rdata_q;
  logic lock_q;
  logic [5:0] tune_q;
  logic [3:0] pump_q;
  logic [5:0] tune_store_q [2];
  logic [3:0] pump_store_q [2];
  logic [5:0] tune_tmp_q;
  logic cal_bank_q;
  logic start_prev_q;
  logic [7:0] ref_cnt_q;
  logic [15:0] cal_cnt_q;
  cal_pkg::cal_state_t st_q;

  // ==========================================================
  // Link decode
  logic acc;
  logic wr_hit;
  logic rd_hit;
  logic bank;
  logic ref_tick;
  logic phase_end;
  logic start_rise;
  logic ovr_on;
  logic [7:0] cal_rd;
  logic [7:0] rd_mux;

  assign acc = ~link.strobe;
  assign wr_hit = acc & link.wr;
  assign rd_hit = acc & ~link.wr;
  assign bank = main_q[`MAIN_BANK_BIT];
  assign ref_tick = (ref_cnt_q == 8'h00);
  assign phase_end = ref_tick & (cal_cnt_q == PHASE_LAST);
  assign start_rise = cal_start_q & ~start_prev_q;
  // Both override bits must be set, one alone is ignored
  assign ovr_on = ovr_vco_q[`OVR_EN_BIT] & ovr_pump_q[`OVR_EN_BIT];
  assign cal_rd = {cal_start_q, cal_shared_q, cal_wait_q, 1'b0, cal_done_q, 3'h0};

  assign rd_mux =
    (link.addr == `REG_MAIN) ? {3'h0, main_q} :
    (link.addr == `REG_CAL) ? cal_rd :
    (link.addr == `REG_LOCK) ? {lock_sel_q, 4'h0} :
    (link.addr == `REG_CURRENT) ? current_q :
    (link.addr == `REG_FRONT) ? {5'h00, front_q} :
    (link.addr == `REG_PAPOW) ? output_power_setting_q :
    (link.addr == `REG_RB_VCO) ? {2'h0, tune_store_q[bank]} :
    (link.addr == `REG_RB_PUMP) ? {4'h0, pump_store_q[bank]} :
    (link.addr == `REG_OVR_VCO) ? ovr_vco_q :
    (link.addr == `REG_OVR_PUMP) ? ovr_pump_q :
    (link.addr == `REG_REFDIV) ? ref_div_q : 8'h00;

  // ==========================================================
  // Configuration writes and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_q <= 5'h00;
      cal_start_q <= 1'b0;
      cal_shared_q <= 1'b0;
      cal_wait_q <= 1'b0;
      lock_sel_q <= 4'h0;
      current_q <= `CURRENT_RST;
      front_q <= 3'h0;
      output_power_setting_q <= `PAPOW_RST;
      ovr_vco_q <= 8'h00;
      ovr_pump_q <= 8'h00;
      ref_div_q <= `REFDIV_RST;
      rdata_q <= 8'h00;
    end else begin
      if (rd_hit) begin
        rdata_q <= rd_mux;
      end
      if (wr_hit) begin
        case (link.addr)
          `REG_MAIN: main_q <= link.wdata[4:0];
          `REG_CAL: begin
            cal_start_q <= link.wdata[`CAL_START_BIT];
            cal_shared_q <= link.wdata[`CAL_SHARED_BIT];
            cal_wait_q <= link.wdata[`CAL_WAIT_BIT];
          end
          `REG_LOCK: lock_sel_q <= link.wdata[7:4];
          `REG_CURRENT: current_q <= link.wdata;
          `REG_FRONT: front_q <= link.wdata[2:0];
          `REG_PAPOW: output_power_setting_q <= link.wdata;
          `REG_OVR_VCO: ovr_vco_q <= link.wdata;
          `REG_OVR_PUMP: ovr_pump_q <= link.wdata;
          `REG_REFDIV: ref_div_q <= link.wdata;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Reference tick: the search runs a fixed number of reference periods,
  // so a slower reference stretches the whole calibration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_q <= 8'h00;
    end else if (ref_tick) begin
      ref_cnt_q <= ref_div_q - 8'h01;
    end else begin
      ref_cnt_q <= ref_cnt_q - 8'h01;
    end
  end

  // ==========================================================
  // Calibration sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= cal_pkg::CAL_IDLE;
      start_prev_q <= 1'b0;
      cal_done_q <= 1'b0;
      cal_cnt_q <= 16'h0000;
      cal_bank_q <= 1'b0;
      tune_tmp_q <= 6'h00;
      tune_store_q[0] <= 6'h00;
      tune_store_q[1] <= 6'h00;
      pump_store_q[0] <= 4'h0;
      pump_store_q[1] <= 4'h0;
    end else begin
      start_prev_q <= cal_start_q;
      case (st_q)
        cal_pkg::CAL_IDLE: begin
          if (start_rise) begin
            st_q <= cal_pkg::CAL_RANGE;
            cal_done_q <= 1'b0;
            cal_cnt_q <= 16'h0000;
            cal_bank_q <= bank;
          end
        end
        cal_pkg::CAL_RANGE, cal_pkg::CAL_PUMP: begin
          if (!cal_start_q) begin
            // Trigger withdrawn mid-search: abandon, stored values stay
            st_q <= cal_pkg::CAL_IDLE;
          end else if (phase_end) begin
            cal_cnt_q <= 16'h0000;
            if (st_q == cal_pkg::CAL_RANGE) begin
              tune_tmp_q <= tune_found;
              st_q <= cal_pkg::CAL_PUMP;
            end else begin
              // Result held until power is lost or a new calibration
              if (cal_shared_q || !cal_bank_q) begin
                tune_store_q[0] <= tune_tmp_q;
                pump_store_q[0] <= pump_found;
              end
              if (cal_shared_q || cal_bank_q) begin
                tune_store_q[1] <= tune_tmp_q;
                pump_store_q[1] <= pump_found;
              end
              cal_done_q <= 1'b1;
              st_q <= cal_pkg::CAL_DONE;
            end
          end else if (ref_tick) begin
            cal_cnt_q <= cal_cnt_q + 16'h0001;
          end
        end
        cal_pkg::CAL_DONE: begin
          if (!cal_start_q) begin
            cal_done_q <= 1'b0;
            st_q <= cal_pkg::CAL_IDLE;
          end
        end
        default: st_q <= cal_pkg::CAL_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Applied analog settings and lock pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tune_q <= 6'h00;
      pump_q <= 4'h0;
      lock_q <= 1'b0;
    end else begin
      tune_q <= ovr_on ? ovr_vco_q[5:0] : tune_store_q[bank];
      pump_q <= ovr_on ? ovr_pump_q[3:0] : pump_store_q[bank];
      lock_q <= (lock_sel_q == `LOCK_SEL_CAL) & cal_done_q;
    end
  end

  assign link.rdata = rdata_q;
  assign link.lock_pin = lock_q;
  assign tune_word = tune_q;
  assign pump_word = pump_q;
  assign rx_pd = main_q[1];
  assign tx_pd = main_q[2];
  assign synth_pd = main_q[3];
  assign xosc_pd = main_q[4];
  assign oscillator_bias_setting = current_q[7:4];
  assign local_osc_buffer_drive = current_q[3:2];
  assign amplifier_buffer_drive = current_q[1:0];
  assign buf_current = front_q[0];
  assign low_noise_amp_bias = front_q[2:1];
  assign output_power_setting = output_power_setting_q;

endmodule

`default_nettype wire

/* File: rtl/cal_host.sv */
// Controller end: APB slave taking orders from software and running link
// accesses, calibration and power-down sequences on the device.
// Assumes the device end shares pclk and answers reads one cycle later.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cal_regs.svh"

module cal_host #(
  parameter logic [23:0] WAIT_CYCLES = 24'(`CAL_WAIT_CYCLES)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  cal_link_if.host link
);

  // ==========================================================
  // APB slave
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [2:0] sts_q;
  logic [2:0] mask_q;
  logic irq_q;
  logic [2:0] sts_set;
  logic [2:0] sts_d;
  logic acc_ph;
  logic xfer_wr;
  logic hit;
  logic idle;
  logic cmd_acc;
  logic cmd_cal;
  logic cmd_pd;
  logic [31:0] rd_mux;
  cal_pkg::host_state_t st_q;
  cal_pkg::job_t job_q;
  logic [1:0] step_q;
  logic [3:0] acc_addr_q;
  logic acc_wr_q;
  logic [7:0] acc_wdata_q;
  logic [7:0] rd_q;
  logic wait_mode_q;
  logic shared_q;
  logic [3:0] pd_q;
  logic pd_bank_q;
  logic [23:0] wait_cnt_q;
  logic oe_q;
  logic [3:0] addr_q;
  logic wr_q;
  logic [7:0] wdata_q;
  logic [3:0] op_addr;
  logic op_wr;
  logic [7:0] op_wdata;

  assign acc_ph = psel & penable;
  assign idle = (st_q == cal_pkg::H_IDLE);
  assign hit = (paddr == `A_ACC) | (paddr == `A_CALCMD) | (paddr == `A_PDCMD) |
               (paddr == `A_STATUS) | (paddr == `A_IRQ_STS) | (paddr == `A_IRQ_MASK);
  assign xfer_wr = acc_ph & pready_q & pwrite & hit;
  // Commands arriving while a sequence runs are dropped
  assign cmd_acc = xfer_wr & idle & (paddr == `A_ACC);
  assign cmd_cal = xfer_wr & idle & (paddr == `A_CALCMD);
  assign cmd_pd = xfer_wr & idle & (paddr == `A_PDCMD);
  assign rd_mux =
    (paddr == `A_ACC) ? {16'h0000, rd_q, 8'h00} :
    (paddr == `A_STATUS) ? {30'h00000000, link.lock_pin, ~idle} :
    (paddr == `A_IRQ_STS) ? {29'h00000000, sts_q} :
    (paddr == `A_IRQ_MASK) ? {29'h00000000, mask_q} : 32'h00000000;
  // Set wins over a write-one-to-clear in the same cycle
  assign sts_d = (sts_q & ~((xfer_wr && paddr == `A_IRQ_STS) ? pwdata[2:0] : 3'h0))
                 | sts_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      sts_q <= 3'h0;
      mask_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      pready_q <= acc_ph & ~pready_q;
      pslverr_q <= acc_ph & ~pready_q & ~hit;
      if (acc_ph && !pready_q) begin
        prdata_q <= rd_mux;
      end
      if (xfer_wr && paddr == `A_IRQ_MASK) begin
        mask_q <= pwdata[2:0];
      end
      sts_q <= sts_d;
      irq_q <= |(sts_d & mask_q);
    end
  end

  // ==========================================================
  // Link operation for the current job and step
  always_comb begin
    op_addr = acc_addr_q;
    op_wr = acc_wr_q;
    op_wdata = acc_wdata_q;
    case (job_q)
      cal_pkg::JOB_CAL: begin
        op_addr = `REG_CAL;
        op_wr = (step_q != 2'h1);
        op_wdata = 8'h00;
        op_wdata[`CAL_START_BIT] = (step_q == 2'h0);
        op_wdata[`CAL_SHARED_BIT] = shared_q;
        op_wdata[`CAL_WAIT_BIT] = wait_mode_q;
      end
      cal_pkg::JOB_PD: begin
        op_addr = (step_q == 2'h0) ? `REG_PAPOW : `REG_MAIN;
        op_wr = 1'b1;
        // Output power cleared before the sections are switched off
        op_wdata = (step_q == 2'h0) ? 8'h00 : {3'h0, pd_q, pd_bank_q};
      end
      default: ;
    endcase
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= cal_pkg::H_IDLE;
      job_q <= cal_pkg::JOB_ACC;
      step_q <= 2'h0;
      acc_addr_q <= 4'h0;
      acc_wr_q <= 1'b0;
      acc_wdata_q <= 8'h00;
      rd_q <= 8'h00;
      wait_mode_q <= 1'b0;
      shared_q <= 1'b0;
      pd_q <= 4'h0;
      pd_bank_q <= 1'b0;
      wait_cnt_q <= 24'h000000;
      oe_q <= 1'b0;
      addr_q <= 4'h0;
      wr_q <= 1'b0;
      wdata_q <= 8'h00;
      sts_set <= 3'h0;
    end else begin
      sts_set <= 3'h0;
      case (st_q)
        cal_pkg::H_IDLE: begin
          step_q <= 2'h0;
          if (cmd_acc) begin
            job_q <= cal_pkg::JOB_ACC;
            acc_addr_q <= pwdata[3:0];
            acc_wdata_q <= pwdata[15:8];
            acc_wr_q <= pwdata[16];
            st_q <= cal_pkg::H_LOAD;
          end else if (cmd_cal) begin
            job_q <= cal_pkg::JOB_CAL;
            wait_mode_q <= pwdata[1];
            shared_q <= pwdata[2];
            st_q <= cal_pkg::H_LOAD;
          end else if (cmd_pd) begin
            job_q <= cal_pkg::JOB_PD;
            pd_q <= pwdata[3:0];
            pd_bank_q <= pwdata[4];
            st_q <= cal_pkg::H_LOAD;
          end
        end
        cal_pkg::H_LOAD: begin
          oe_q <= 1'b1;
          addr_q <= op_addr;
          wr_q <= op_wr;
          wdata_q <= op_wdata;
          st_q <= cal_pkg::H_ISSUE;
        end
        cal_pkg::H_ISSUE: begin
          // Strobe released between accesses: the pull-up holds it high
          oe_q <= 1'b0;
          st_q <= cal_pkg::H_RESP;
        end
        cal_pkg::H_RESP: begin
          if (!wr_q) begin
            rd_q <= link.rdata;
          end
          st_q <= cal_pkg::H_LOAD;
          case (job_q)
            cal_pkg::JOB_CAL: begin
              if (step_q == 2'h0) begin
                step_q <= 2'h1;
                wait_cnt_q <= 24'h000000;
                if (wait_mode_q) begin
                  st_q <= cal_pkg::H_WAIT;
                end
              end else if (step_q == 2'h1) begin
                if (link.rdata[`CAL_DONE_BIT]) begin
                  step_q <= 2'h2;
                end
              end else begin
                sts_set[`IRQ_CAL_BIT] <= 1'b1;
                st_q <= cal_pkg::H_IDLE;
              end
            end
            cal_pkg::JOB_PD: begin
              step_q <= 2'h1;
              if (step_q != 2'h0) begin
                sts_set[`IRQ_PD_BIT] <= 1'b1;
                st_q <= cal_pkg::H_IDLE;
              end
            end
            default: begin
              sts_set[`IRQ_ACC_BIT] <= 1'b1;
              st_q <= cal_pkg::H_IDLE;
            end
          endcase
        end
        cal_pkg::H_WAIT: begin
          wait_cnt_q <= wait_cnt_q + 24'h000001;
          if (wait_cnt_q == WAIT_CYCLES - 24'h000001) begin
            step_q <= 2'h2;
            st_q <= cal_pkg::H_LOAD;
          end
        end
        default: st_q <= cal_pkg::H_IDLE;
      endcase
    end
  end

  assign link.strobe_o = 1'b0;
  assign link.strobe_oe = oe_q;
  assign link.addr = addr_q;
  assign link.wr = wr_q;
  assign link.wdata = wdata_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

endmodule

`default_nettype wire

/* File: rtl/cal_link_if.sv */
// Configuration link between the controller and the transceiver control
// logic. Both ends run on the same pclk; the strobe pin has a pull-up.
`timescale 1ns/1ps
`default_nettype none

interface cal_link_if;
  logic strobe_o;
  logic strobe_oe;
  logic strobe;
  logic [3:0] addr;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic lock_pin;

  // Internal pull-up: an undriven strobe reads high
  assign strobe = strobe_oe ? strobe_o : 1'b1;

  modport dev (
    input strobe,
    input addr,
    input wr,
    input wdata,
    output rdata,
    output lock_pin
  );

  modport host (
    output strobe_o,
    output strobe_oe,
    output addr,
    output wr,
    output wdata,
    input strobe,
    input rdata,
    input lock_pin
  );
endinterface

`default_nettype wire

/* File: rtl/cal_pkg.sv */
// Types shared by the device end and the controller end.
// Assumes nothing beyond a SystemVerilog compiler.
package cal_pkg;

  typedef enum logic [3:0] {
    CAL_IDLE = 4'b0001,
    CAL_RANGE = 4'b0010,
    CAL_PUMP = 4'b0100,
    CAL_DONE = 4'b1000
  } cal_state_t;

  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_LOAD = 5'b00010,
    H_ISSUE = 5'b00100,
    H_RESP = 5'b01000,
    H_WAIT = 5'b10000
  } host_state_t;

  typedef enum logic [1:0] {
    JOB_ACC = 2'h0,
    JOB_CAL = 2'h1,
    JOB_PD = 2'h2
  } job_t;

endpackage

/* File: rtl/cal_regs.svh */
// Register offsets, field positions, reset values and timing counts for the
// calibration controller pair. Included by both ends; definitions only.
`ifndef CAL_REGS_SVH
`define CAL_REGS_SVH

// ==========================================================
// Timing
`define PCLK_MHZ 250
`define CAL_WORST_MS 34
`define REF_MIN_MHZ 1
`define CAL_REF_CYCLES (`CAL_WORST_MS * 1000 * `REF_MIN_MHZ)
`define CAL_WAIT_CYCLES (`CAL_WORST_MS * 1000 * `PCLK_MHZ)

// ==========================================================
// Device register offsets (4-bit address on the link)
`define REG_MAIN 4'h0
`define REG_CAL 4'h1
`define REG_LOCK 4'h2
`define REG_CURRENT 4'h3
`define REG_FRONT 4'h4
`define REG_PAPOW 4'h5
`define REG_RB_VCO 4'h6
`define REG_RB_PUMP 4'h7
`define REG_OVR_VCO 4'h8
`define REG_OVR_PUMP 4'h9
`define REG_REFDIV 4'ha

// ==========================================================
// Device fields and reset values
`define MAIN_BANK_BIT 0
`define CAL_START_BIT 7
`define CAL_SHARED_BIT 6
`define CAL_WAIT_BIT 5
`define CAL_DONE_BIT 3
`define OVR_EN_BIT 7
`define LOCK_SEL_CAL 4'h1
`define REFDIV_RST 8'hfa
`define CURRENT_RST 8'h00
`define PAPOW_RST 8'h00

// ==========================================================
// Controller APB map (byte addresses)
`define A_ACC 8'h00
`define A_CALCMD 8'h04
`define A_PDCMD 8'h08
`define A_STATUS 8'h0c
`define A_IRQ_STS 8'h10
`define A_IRQ_MASK 8'h14
`define IRQ_ACC_BIT 0
`define IRQ_CAL_BIT 1
`define IRQ_PD_BIT 2

`endif

/* File: verification/cal_link_properties.sv */
// Checker: concurrent properties on the link between controller and device.
// Assumes one pclk domain and an asynchronous active-low presetn.
`timescale 1ns/1ps
`default_nettype none
`include "cal_regs.svh"

module cal_link_properties #(
  parameter int unsigned CAL_REF_CYCLES = `CAL_REF_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic strobe_o,
  input wire logic strobe_oe,
  input wire logic strobe,
  input wire logic [3:0] addr,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic lock_pin
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========
  // Helper logic
  wire logic cal_wr = !strobe && wr && addr == `REG_CAL;
  wire logic lock_wr = !strobe && wr && addr == `REG_LOCK;
  wire logic rd_hit = !strobe && !wr;
  wire logic start_wr = cal_wr && wdata[`CAL_START_BIT];
  logic [3:0] sel_q;
  logic [31:0] since_q;
  wire logic [3:0] sel_d = lock_wr ? wdata[7:4] : sel_q;
  // Saturates so a long idle stretch never wraps back under the minimum
  wire logic [31:0] since_d = start_wr ? 32'h0 : since_q + {31'h0, ~&since_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= 4'h0;
      since_q <= 32'h0;
    end else begin
      sel_q <= sel_d;
      since_q <= since_d;
    end
  end

  // ==========
  // Assertions
  AST_STROBE_GAP: assert property (!strobe |=> strobe [*2])
    else $error("link accesses closer than three cycles");
  AST_DRIVE_LOW: assert property (strobe_oe |-> !strobe_o)
    else $error("strobe driven high instead of released");
  AST_PULL_UP: assert property (!strobe_oe |-> strobe)
    else $error("released strobe not high");
  AST_RDATA_HOLD: assert property ($changed(rdata) |-> $past(rd_hit))
    else $error("read data changed without a read");
  AST_LOCK_SELECT: assert property (lock_pin |-> $past(sel_q) == `LOCK_SEL_CAL)
    else $error("lock pin high without done source selected");
  AST_LOCK_HOLD: assert property ($fell(lock_pin) |-> $past(cal_wr || lock_wr) ||
      $past(cal_wr || lock_wr, 2) || $past(cal_wr || lock_wr, 3))
    else $error("done flag dropped without a host write");
  AST_LOCK_CLEAR: assert property (cal_wr && !wdata[`CAL_START_BIT] |-> ##[1:3] !lock_pin)
    else $error("done flag kept after trigger cleared");
  AST_START_CLEARS: assert property (start_wr |-> ##[1:3] !lock_pin)
    else $error("done flag not cleared at start");
  AST_CAL_MIN: assert property ($rose(lock_pin) |-> since_q >= CAL_REF_CYCLES)
    else $error("calibration finished too early");

  COV_DONE: cover property ($rose(lock_pin));
  COV_START: cover property (start_wr);
  COV_READBACK: cover property (rd_hit && addr == `REG_RB_VCO);
endmodule

`default_nettype wire

/* File: verification/tb_pll_self_calibration_ctrl.sv */
// Testbench: APB software drives the controller, which calibrates and
// configures the device end across the link. Short counts keep it brief.
`timescale 1ns/1ps
`default_nettype none
`include "cal_regs.svh"

module tb_pll_self_calibration_ctrl;
  localparam int unsigned CAL_REF = 20;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] tune_found = 6'h0;
  logic [3:0] pump_found = 4'h0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, irq, rx_pd, tx_pd, synth_pd, xosc_pd, buf_current;
  wire logic [5:0] tune_word;
  wire logic [3:0] pump_word, oscillator_bias_setting;
  wire logic [1:0] local_osc_buffer_drive, amplifier_buffer_drive, low_noise_amp_bias;
  wire logic [7:0] output_power_setting;
  int mismatches = 0;
  int n_tests = 0;
  logic [31:0] rd;
  logic err;

  always #2 pclk = ~pclk;

  // ==========
  // Both ends across the link
  cal_link_if cal_link_if_i ();
  cal_device #(.CAL_REF_CYCLES(CAL_REF)) cal_device_i (.pclk(pclk), .presetn(presetn),
    .link(cal_link_if_i), .tune_found(tune_found), .pump_found(pump_found),
    .tune_word(tune_word), .pump_word(pump_word), .rx_pd(rx_pd), .tx_pd(tx_pd),
    .synth_pd(synth_pd), .xosc_pd(xosc_pd), .oscillator_bias_setting(oscillator_bias_setting),
    .local_osc_buffer_drive(local_osc_buffer_drive), .buf_current(buf_current),
    .amplifier_buffer_drive(amplifier_buffer_drive), .low_noise_amp_bias(low_noise_amp_bias),
    .output_power_setting(output_power_setting));
  cal_host #(.WAIT_CYCLES(24'hc8)) cal_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(cal_link_if_i));
  cal_link_properties #(.CAL_REF_CYCLES(CAL_REF)) cal_link_properties_i (.pclk(pclk),
    .presetn(presetn), .strobe_o(cal_link_if_i.strobe_o), .strobe_oe(cal_link_if_i.strobe_oe),
    .strobe(cal_link_if_i.strobe), .addr(cal_link_if_i.addr), .wr(cal_link_if_i.wr),
    .wdata(cal_link_if_i.wdata), .rdata(cal_link_if_i.rdata), .lock_pin(cal_link_if_i.lock_pin));

  // ==========
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Idle cycle after each transfer keeps one assignment per signal per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // No fixed wait assumed: only the watchdog ends a hung transfer
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic wait_idle();
    apb(1'h0, `A_STATUS, 32'h0);
    while (rd[0] !== 1'h0) apb(1'h0, `A_STATUS, 32'h0);
  endtask

  task automatic dev_acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    apb(1'h1, `A_ACC, {15'h0, w, d, 4'h0, a});
    wait_idle();
    apb(1'h0, `A_ACC, 32'h0);
  endtask

  task automatic cal(input logic [31:0] cmd, input logic [5:0] t, input logic [3:0] p);
    tune_found <= t;
    pump_found <= p;
    apb(1'h1, `A_CALCMD, cmd);
    wait_idle();
    repeat (3) @(posedge pclk);
    chk("irq on done", 32'h1, {31'h0, irq});
    apb(1'h1, `A_IRQ_STS, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask

  task automatic rb(input logic [5:0] t, input logic [3:0] p);
    dev_acc(1'h0, `REG_RB_VCO, 8'h0);
    chk("readback tune", {26'h0, t}, {26'h0, rd[13:8]});
    dev_acc(1'h0, `REG_RB_PUMP, 8'h0);
    chk("readback pump", {28'h0, p}, {28'h0, rd[11:8]});
  endtask

  // ==========
  // Sequence
  initial begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, 8'h18, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'h0, `A_STATUS, 32'h0);
    chk("status after reset", 32'h0, rd);
    dev_acc(1'h1, `REG_REFDIV, 8'h02);
    dev_acc(1'h1, `REG_LOCK, {`LOCK_SEL_CAL, 4'h0});
    dev_acc(1'h1, `REG_CURRENT, 8'h84);
    dev_acc(1'h1, `REG_FRONT, 8'h05);
    chk("bias fields", 32'h426, {oscillator_bias_setting, local_osc_buffer_drive,
      amplifier_buffer_drive, buf_current, low_noise_amp_bias});
    dev_acc(1'h0, `REG_CURRENT, 8'h0);
    chk("current readback", 32'h84, {24'h0, rd[15:8]});
    apb(1'h0, `A_IRQ_STS, 32'h0);
    chk("masked access event", 32'h2, {rd[30:0], irq});
    apb(1'h1, `A_IRQ_MASK, 32'h2);
    cal(32'h0, 6'h2a, 4'h5);
    rb(6'h2a, 4'h5);
    chk("tune applied", 32'h2a, {26'h0, tune_word});
    dev_acc(1'h1, `REG_MAIN, 8'h01);
    cal(32'h0, 6'h11, 4'h9);
    rb(6'h11, 4'h9);
    dev_acc(1'h1, `REG_MAIN, 8'h00);
    rb(6'h2a, 4'h5);
    cal(32'h6, 6'h3c, 4'hc);
    rb(6'h3c, 4'hc);
    dev_acc(1'h1, `REG_MAIN, 8'h01);
    rb(6'h3c, 4'hc);
    dev_acc(1'h1, `REG_OVR_VCO, 8'h95);
    chk("one override bit", 32'h3cc, {22'h0, tune_word, pump_word});
    dev_acc(1'h1, `REG_OVR_PUMP, 8'h83);
    chk("both override bits", 32'h153, {22'h0, tune_word, pump_word});
    dev_acc(1'h1, `REG_OVR_VCO, 8'h15);
    chk("override dropped", 32'h3cc, {22'h0, tune_word, pump_word});
    apb(1'h1, `A_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("unmasked access irq", 32'h1, {31'h0, irq});
    apb(1'h1, `A_IRQ_MASK, 32'h0);
    dev_acc(1'h1, `REG_PAPOW, 8'hff);
    apb(1'h1, `A_PDCMD, 32'h0f);
    wait_idle();
    chk("all sections down", 32'h0f, {xosc_pd, synth_pd, tx_pd, rx_pd});
    chk("power zeroed", 32'h0, {24'h0, output_power_setting});
    apb(1'h1, `A_PDCMD, 32'h05);
    wait_idle();
    chk("rx and synth down", 32'h05, {xosc_pd, synth_pd, tx_pd, rx_pd});
    chk("strobe released", 32'h1, {31'h0, cal_link_if_i.strobe});
    apb(1'h0, `A_IRQ_STS, 32'h0);
    chk("access and pd events", 32'h5, rd);
    end_of_test();
  end
endmodule

`default_nettype wire
